// file: verilog/fbg_glue.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - The decoder answers I/O ports F3H to F7H and ignores all other ports.
// - Ports F4H to F7H pass to the formatter: status/command, track, sector, data.
// - Writing F3H latches drive selects, side, 5.25 size, single density, waits.
// - Reading F3H returns the latched bits, with D5 the strap-selected size and D7 flagging a one-sided disk.
// - Precompensation is on only in double density above track 43.
// - The interrupt vector comes from eight jumpers, fitted reads one, 0036H.
// - Disk size comes from a strap, or with soft strap from the latch size bit.
// - Priority chain: open input means highest, output feeds the next board.
// - Up to four drives of mixed size, one selected at a time.
module fbg_glue
  import fbg_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            reset,
  input  wire logic [7:0]      port_addr,
  input  wire logic            io_rd,
  input  wire logic            io_wr,
  input  wire logic [7:0]      io_wdata,
  input  wire logic            int_ack,
  input  wire logic            fdc_irq,
  input  wire logic [7:0]      fdc_rdata,
  input  wire logic [7:0]      fdc_track_now,
  input  wire logic            one_sided_disk,
  input  wire logic [7:0]      vector_jumpers,
  input  wire fbg_pkg::fbg_size_strap_e size_strap,
  input  wire logic            prio_in_n,
  output logic [7:0]           io_rdata,
  output logic                 io_rdata_valid,
  output logic [7:0]           vector_out,
  output logic                 vector_valid,
  output logic                 int_req,
  output logic                 prio_out_n,
  output fbg_pkg::fbg_fdc_bus_s fdc_bus,
  output logic [3:0]           drive_select,
  output logic                 side1,
  output logic                 size_5in,
  output logic                 single_density_select,
  output logic                 wait_enable,
  output logic                 precomp_enable
);
  import fbg_pkg::*;

  fbg_ctrl_s  ctrl_reg;
  logic       hit_drive;
  logic       hit_fdc;
  logic [1:0] fdc_reg;
  logic       size_next;
  logic [3:0] sel_next;

  fbg_decode u_dec (
    .port_addr (port_addr),
    .hit_drive (hit_drive),
    .hit_fdc   (hit_fdc),
    .fdc_reg   (fdc_reg)
  );

  // Only the lowest requested select bit survives, so one drive at a time.
  always_comb begin
    sel_next = io_wdata[3:0] & (~io_wdata[3:0] + 4'h1);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= fbg_ctrl_s'(FBG_CTRL_RESET);
    end else if (io_wr && hit_drive) begin
      ctrl_reg.drive_select          <= sel_next;
      ctrl_reg.side1                 <= io_wdata[FBG_BIT_SIDE];
      ctrl_reg.size_5in              <= io_wdata[FBG_BIT_SIZE];
      ctrl_reg.single_density_select <= io_wdata[FBG_BIT_SDEN];
      ctrl_reg.wait_enable           <= io_wdata[FBG_BIT_WAIT];
    end
  end

  always_comb begin
    unique case (size_strap)
      FBG_SIZE_8IN:  size_next = 1'b0;
      FBG_SIZE_5IN:  size_next = 1'b1;
      FBG_SIZE_SOFT: size_next = ctrl_reg.size_5in;
      default:       size_next = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      drive_select          <= 4'h0;
      side1                 <= 1'b0;
      size_5in              <= 1'b0;
      single_density_select <= 1'b0;
      wait_enable           <= 1'b0;
      precomp_enable        <= 1'b0;
    end else begin
      drive_select          <= ctrl_reg.drive_select;
      side1                 <= ctrl_reg.side1;
      size_5in              <= size_next;
      single_density_select <= ctrl_reg.single_density_select;
      wait_enable           <= ctrl_reg.wait_enable;
      precomp_enable        <= !ctrl_reg.single_density_select &&
                               (fdc_track_now > FBG_PRECOMP_TRK);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fdc_bus <= '0;
    end else begin
      fdc_bus.cs    <= (io_rd || io_wr) && hit_fdc;
      fdc_bus.rd    <= io_rd && hit_fdc;
      fdc_bus.wr    <= io_wr && hit_fdc;
      fdc_bus.addr  <= fdc_reg;
      fdc_bus.wdata <= io_wdata;
    end
  end

  // Drive port reads answer one edge after the request; formatter reads
  // answer one edge after the registered strobe, two after the request.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      io_rdata       <= 8'h00;
      io_rdata_valid <= 1'b0;
    end else begin
      io_rdata_valid <= (io_rd && hit_drive) ||
                        fdc_bus.rd;
      if (io_rd && hit_drive) begin
        io_rdata <= {one_sided_disk, ctrl_reg.single_density_select,
                     size_next, ctrl_reg.side1,
                     ctrl_reg.drive_select};
      end else if (fdc_bus.rd) begin
        io_rdata <= fdc_rdata;
      end else begin
        io_rdata <= 8'h00;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      int_req      <= 1'b0;
      prio_out_n   <= 1'b1;
      vector_out   <= 8'h00;
      vector_valid <= 1'b0;
    end else begin
      int_req      <= fdc_irq && !prio_in_n;
      prio_out_n   <= !(!prio_in_n && !fdc_irq);
      vector_valid <= int_ack && fdc_irq && !prio_in_n;
      vector_out   <= (int_ack && fdc_irq && !prio_in_n) ?
                      vector_jumpers : 8'h00;
    end
  end

  // Checks sample one or two edges after the request, as the outputs do.
  a_ignore_other: assert property (@(posedge mclk)
    disable iff (reset)
    (io_rd && !(hit_drive || hit_fdc) && !fdc_bus.rd) |=>
      !io_rdata_valid)
    else $error("read of unmapped port answered");
  a_decode_range: assert property (@(posedge mclk)
    disable iff (reset)
    (port_addr < FBG_PORT_DRIVE || port_addr > FBG_PORT_DATA) |->
      !hit_drive && !hit_fdc)
    else $error("unmapped port decoded");
  a_fdc_pass: assert property (@(posedge mclk)
    disable iff (reset)
    (io_wr && hit_fdc) |=> fdc_bus.wr && fdc_bus.cs)
    else $error("formatter write not passed");
  a_fdc_read_valid: assert property (@(posedge mclk)
    disable iff (reset)
    (io_rd && hit_fdc) |=> ##1 io_rdata_valid)
    else $error("formatter read not answered");
  a_cmd_latch: assert property (@(posedge mclk)
    disable iff (reset)
    (io_wr && hit_drive) |=> ##1 side1 == $past(io_wdata[FBG_BIT_SIDE], 2))
    else $error("side bit not latched");
  a_latch_hold: assert property (@(posedge mclk)
    disable iff (reset)
    !(io_wr && hit_drive) |=> $stable(ctrl_reg))
    else $error("command latch changed without a write");
  a_status_read: assert property (@(posedge mclk)
    disable iff (reset)
    (io_rd && hit_drive) |=> io_rdata[7] == $past(one_sided_disk))
    else $error("one sided flag wrong");
  a_drive_read_valid: assert property (@(posedge mclk)
    disable iff (reset)
    (io_rd && hit_drive) |=> io_rdata_valid)
    else $error("drive status read not answered");
  a_precomp_gate: assert property (@(posedge mclk)
    disable iff (reset)
    precomp_enable |-> !$past(ctrl_reg.single_density_select) &&
      $past(fdc_track_now) > FBG_PRECOMP_TRK)
    else $error("precomp outside double density high tracks");
  a_sden_no_precomp: assert property (@(posedge mclk)
    disable iff (reset)
    ctrl_reg.single_density_select |=> !precomp_enable)
    else $error("precomp on in single density");
  a_vector_out: assert property (@(posedge mclk)
    disable iff (reset)
    vector_valid |-> vector_out == $past(vector_jumpers))
    else $error("vector not from jumpers");
  a_vector_grant: assert property (@(posedge mclk)
    disable iff (reset)
    (int_ack && fdc_irq && !prio_in_n) |=> vector_valid)
    else $error("vector not given on acknowledge");
  a_size_strap: assert property (@(posedge mclk)
    disable iff (reset)
    (size_strap == FBG_SIZE_8IN) |=> !size_5in)
    else $error("8 inch strap ignored");
  a_strap_5in: assert property (@(posedge mclk)
    disable iff (reset)
    (size_strap == FBG_SIZE_5IN) |=> size_5in)
    else $error("5.25 inch strap ignored");
  a_prio_chain: assert property (@(posedge mclk)
    disable iff (reset)
    prio_in_n |=> !int_req && prio_out_n)
    else $error("priority chain violated");
  a_int_req_gate: assert property (@(posedge mclk)
    disable iff (reset)
    (fdc_irq && !prio_in_n) |=> int_req)
    else $error("granted request not raised");
  a_prio_pass: assert property (@(posedge mclk)
    disable iff (reset)
    (!prio_in_n && !fdc_irq) |=> !prio_out_n)
    else $error("idle board did not pass priority");
  a_one_drive: assert property (@(posedge mclk)
    disable iff (reset)
    $onehot0(drive_select))
    else $error("more than one drive selected");
  a_reset_clear: assert property (@(posedge mclk)
    $past(reset) |-> ctrl_reg == fbg_ctrl_s'(FBG_CTRL_RESET))
    else $error("command latch not cleared by reset");
  c_drive_write: cover property (@(posedge mclk) io_wr && hit_drive);
  c_fdc_read: cover property (@(posedge mclk) io_rd && hit_fdc);
  c_precomp: cover property (@(posedge mclk) precomp_enable);
  c_vector: cover property (@(posedge mclk) vector_valid);
  c_prio_pass: cover property (@(posedge mclk) !prio_out_n);
endmodule
`default_nettype wire

// file: inc/fbg_pkg.sv
package fbg_pkg;
  localparam logic [7:0] FBG_PORT_DRIVE  = 8'hF3;
  localparam logic [7:0] FBG_PORT_STATUS = 8'hF4;
  localparam logic [7:0] FBG_PORT_TRACK  = 8'hF5;
  localparam logic [7:0] FBG_PORT_SECTOR = 8'hF6;
  localparam logic [7:0] FBG_PORT_DATA   = 8'hF7;
  localparam logic [7:0] FBG_CTRL_RESET  = 8'h00;
  localparam logic [7:0] FBG_PRECOMP_TRK = 8'h2B;
  localparam logic [7:0] FBG_VECTOR_DEF  = 8'h36;
  localparam int         FBG_BIT_SIDE    = 4;
  localparam int         FBG_BIT_SIZE    = 5;
  localparam int         FBG_BIT_SDEN    = 6;
  localparam int         FBG_BIT_WAIT    = 7;

  typedef enum logic [1:0] {
    FBG_SIZE_8IN,
    FBG_SIZE_5IN,
    FBG_SIZE_SOFT
  } fbg_size_strap_e;

  typedef struct packed {
    logic       wait_enable;
    logic       single_density_select;
    logic       size_5in;
    logic       side1;
    logic [3:0] drive_select;
  } fbg_ctrl_s;

  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [1:0] addr;
    logic [7:0] wdata;
  } fbg_fdc_bus_s;
endpackage

// file: verilog/fbg_decode.sv
`timescale 1ns/100ps
`default_nettype none
module fbg_decode
  import fbg_pkg::*;
(
  input  wire logic [7:0] port_addr,
  output logic            hit_drive,
  output logic            hit_fdc,
  output logic [1:0]      fdc_reg
);
  always_comb begin
    hit_drive = (port_addr == FBG_PORT_DRIVE);
    hit_fdc   = (port_addr >= FBG_PORT_STATUS) &&
                (port_addr <= FBG_PORT_DATA);
    fdc_reg   = 2'(port_addr - FBG_PORT_STATUS);
  end
endmodule
`default_nettype wire

// file: dv/fbg_host.sv
`timescale 1ns/100ps
`default_nettype none
module fbg_host (
  input  wire logic       mclk,
  input  wire logic       io_rdata_valid,
  input  wire logic [7:0] io_rdata,
  output logic [7:0]      port_addr,
  output logic            io_rd,
  output logic            io_wr,
  output logic [7:0]      io_wdata
);
  initial begin
    port_addr = 8'h00;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_wdata = 8'h00;
  end
  // An idle bus shows the inverse of the last address; data is inverted after a write, and a read leaves it as it was.
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    port_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge mclk);
    io_wr <= 1'b0;
    port_addr <= ~a;
    io_wdata <= ~d;
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d,
                     output logic ok);
    @(posedge mclk);
    port_addr <= a;
    io_rd <= 1'b1;
    @(posedge mclk);
    io_rd <= 1'b0;
    port_addr <= ~a;
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (io_rdata_valid === 1'b1) begin
        ok = 1'b1;
        d = io_rdata;
      end else @(posedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// file: dv/fbg_glue_tb.sv
`timescale 1ns/100ps
`default_nettype none
module fbg_glue_tb;
  import fbg_pkg::*;
  logic            mclk, reset, int_ack, fdc_irq, one_sided_disk, prio_in_n;
  logic            io_rd, io_wr, io_rdata_valid, vector_valid, int_req, ok;
  logic            prio_out_n, side1, size_5in, single_density_select;
  logic            wait_enable, precomp_enable;
  logic [7:0]      port_addr, io_wdata, io_rdata, vector_out, r, d;
  logic [7:0]      fdc_track_now;
  logic [3:0]      drive_select;
  fbg_size_strap_e size_strap;
  fbg_fdc_bus_s    fdc_bus;
  logic [7:0]      jumpers, fdc_rd_byte;
  int              n_errors = 0;
  int              checks_done = 0;
  always #5 mclk = ~mclk;
  fbg_host HOST (.mclk(mclk), .io_rdata_valid(io_rdata_valid),
    .io_rdata(io_rdata), .port_addr(port_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata));
  fbg_glue DUT (.mclk(mclk), .reset(reset), .port_addr(port_addr),
    .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .int_ack(int_ack),
    .fdc_irq(fdc_irq), .fdc_rdata(fdc_rd_byte),
    .fdc_track_now(fdc_track_now),
    .one_sided_disk(one_sided_disk), .vector_jumpers(jumpers),
    .size_strap(size_strap), .prio_in_n(prio_in_n), .io_rdata(io_rdata),
    .io_rdata_valid(io_rdata_valid), .vector_out(vector_out),
    .vector_valid(vector_valid), .int_req(int_req),
    .prio_out_n(prio_out_n), .fdc_bus(fdc_bus),
    .drive_select(drive_select), .side1(side1), .size_5in(size_5in),
    .single_density_select(single_density_select),
    .wait_enable(wait_enable), .precomp_enable(precomp_enable));
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  function automatic logic [7:0] outs();
    return {wait_enable, single_density_select, size_5in, side1,
            drive_select};
  endfunction
  task automatic t_drive();
    for (int i = 0; i < 4; i++) begin
      d = {i[0], ~i[0], 1'b1, i[1], 4'h1 << i};
      one_sided_disk <= i[0];
      HOST.put(FBG_PORT_DRIVE, d);
      @(posedge mclk);
      #1 chk("drive_outs", d, outs());
      HOST.get(FBG_PORT_DRIVE, r, ok);
      chk("drive_status", {i[0], d[6:0]}, r);
    end
    HOST.put(FBG_PORT_DRIVE, 8'h0C);
    @(posedge mclk);
    #1 chk("one_drive", 4'h4, drive_select);
    $display("test drive done");
  endtask
  task automatic t_reset();
    HOST.put(FBG_PORT_DRIVE, 8'hD1);
    repeat (2) @(posedge mclk);
    #1 chk("pre_reset", 8'hD1, outs());
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk("reset_hold", 9'h001, {outs(), prio_out_n});
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("reset_after", 8'h00, outs());
    $display("test reset done");
  endtask
  task automatic t_strap();
    HOST.put(FBG_PORT_DRIVE, 8'h20);
    size_strap <= FBG_SIZE_8IN;
    repeat (3) @(posedge mclk);
    #1 chk("size_8in", 0, size_5in);
    size_strap <= FBG_SIZE_5IN;
    HOST.put(FBG_PORT_DRIVE, 8'h00);
    repeat (2) @(posedge mclk);
    #1 chk("size_5in", 1, size_5in);
    size_strap <= FBG_SIZE_SOFT;
    repeat (3) @(posedge mclk);
    #1 chk("size_soft", 0, size_5in);
    $display("test strap done");
  endtask
  task automatic t_precomp(input logic [7:0] c, input logic [7:0] t,
                           input logic e);
    HOST.put(FBG_PORT_DRIVE, c);
    fdc_track_now <= t;
    repeat (3) @(posedge mclk);
    #1 chk("precomp", e, precomp_enable);
    $display("test precomp done");
  endtask
  task automatic t_fdc();
    for (int a = 8'hF4; a <= 8'hF7; a++) begin
      HOST.put(a[7:0], a[7:0] ^ 8'h5A);
      #1 chk("fdc_wr", {3'b101, a[1:0] - 2'd0, a[7:0] ^ 8'h5A}, fdc_bus);
      fdc_rd_byte <= a[7:0] ^ 8'hA5;
      HOST.get(a[7:0], r, ok);
      chk("fdc_rd", {1'b1, a[7:0] ^ 8'hA5}, {ok, r});
    end
    HOST.get(8'hF2, r, ok);
    chk("miss_lo", 0, ok);
    HOST.get(8'hF8, r, ok);
    chk("miss_hi", 0, ok);
    HOST.put(8'hF8, 8'hFF);
    #1 chk("miss_bus", 0, fdc_bus.cs);
    HOST.put(8'hF2, 8'hFF);
    repeat (2) @(posedge mclk);
    #1 chk("miss_drv", 8'h00, outs());
    $display("test fdc done");
  endtask
  task automatic t_irq();
    fdc_irq <= 1'b1;
    prio_in_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk("no_grant", 0, int_req);
    prio_in_n <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("req_hold", 2'b11, {int_req, prio_out_n});
    int_ack <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk("vector", {1'b1, FBG_VECTOR_DEF},
           {vector_valid, vector_out});
    jumpers <= 8'hA5;
    repeat (2) @(posedge mclk);
    #1 chk("vector_jmp", {1'b1, 8'hA5}, {vector_valid, vector_out});
    int_ack <= 1'b0;
    fdc_irq <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk("pass_on", 0, prio_out_n);
    $display("test irq done");
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    {int_ack, fdc_irq, one_sided_disk, prio_in_n} = 4'h0;
    fdc_track_now = 8'h00;
    size_strap = FBG_SIZE_SOFT;
    jumpers = FBG_VECTOR_DEF;
    fdc_rd_byte = 8'h00;
    repeat (16) @(posedge mclk);
    #1 chk("reset", 9'h001, {outs(), prio_out_n});
    reset <= 1'b0;
    t_drive();
    t_reset();
    t_strap();
    t_precomp(8'h01, 8'd43, 1'b0);
    t_precomp(8'h01, 8'd44, 1'b1);
    t_precomp(8'h41, 8'd44, 1'b0);
    HOST.put(FBG_PORT_DRIVE, 8'h00);
    t_fdc();
    t_irq();
    finish_test();
  end
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
